// ### src/cmb_axil.v
// axi4-lite slave front end for the command unit registers
`timescale 1ns/100ps
`include "cmb_consts.vh"
module cmb_axil (
  input wire clk,
  input wire reset,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg wr_en_q,
  output reg [7:0] wr_addr_q,
  output reg [15:0] wr_data_q,
  output wire [7:0] rd_addr,
  input wire [15:0] rd_data,
  input wire rd_hit
);
  // ----------------------------------------------------------------
  // write side: address and data may arrive in either order
  // ----------------------------------------------------------------
  reg aw_have_q; // address word latched
  reg w_have_q; // data word latched
  reg [7:0] aw_q;
  reg [15:0] w_q;
  reg w_low_q; // both low byte lanes were enabled
  function hit_w;
    input [7:0] a;
    begin
      hit_w = (a == `CMB_ADDR_CTRL) || (a == `CMB_ADDR_STATUS);
    end
  endfunction
  always @(posedge clk) begin
    wr_en_q <= 1'b0;
    if (reset) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_q <= 8'h00;
      w_q <= 16'h0000;
      w_low_q <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CMB_RESP_OKAY;
      wr_addr_q <= 8'h00;
      wr_data_q <= 16'h0000;
    end else begin
      s_axi_awready <= !aw_have_q && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !w_have_q && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_q <= s_axi_wdata[15:0];
        w_low_q <= &s_axi_wstrb[1:0];
        s_axi_wready <= 1'b0;
      end
      // both halves held: perform and answer
      if (aw_have_q && w_have_q && !s_axi_bvalid) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        wr_en_q <= hit_w(aw_q) && w_low_q;
        wr_addr_q <= aw_q;
        wr_data_q <= w_q;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= hit_w(aw_q) ? `CMB_RESP_OKAY : `CMB_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // ----------------------------------------------------------------
  // read side: data one cycle after the address is taken
  // ----------------------------------------------------------------
  assign rd_addr = s_axi_araddr;
  always @(posedge clk) begin
    if (reset) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `CMB_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        // narrow data in the low half, upper half reads zero
        s_axi_rdata <= {16'h0000, rd_hit ? rd_data : 16'h0000};
        s_axi_rresp <= rd_hit ? `CMB_RESP_OKAY : `CMB_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // cmb_axil

// ### src/cmb_consts.vh
// constants for the cpu module bus command unit
`ifndef CMB_CONSTS_VH
`define CMB_CONSTS_VH
// ----------------------------------------------------------------
// microcode field codes
// ----------------------------------------------------------------
`define CMB_FC_NONE 3'h0
`define CMB_FC_CTRL 3'h1
`define CMB_FC_CMD 3'h2
`define CMB_FC_NEXT 3'h3
`define CMB_FC_OPERAND_REGISTER 3'h4
// ----------------------------------------------------------------
// field positions, bit 0 is the msb of a 16-bit word
// ----------------------------------------------------------------
`define CMB_DEST_FIRST 13
`define CMB_OPC_FIRST 10
`define CMB_ORG_SRC_FIRST 5
`define CMB_ORG_OPC_FIRST 2
`define CMB_STATUS_FLAG_BIT 7
`define CMB_OPC_NOP 2'h0
// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define CMB_ADDR_CTRL 8'h00
`define CMB_ADDR_STATUS 8'h04
`define CMB_ADDR_ORIGIN 8'h08
`define CMB_ADDR_NEXT 8'h0C
`define CMB_ADDR_OPERAND_REGISTER 8'h10
`define CMB_ADDR_OWN 8'h14
// ----------------------------------------------------------------
// reset values and responses
// ----------------------------------------------------------------
`define CMB_CTRL_RESET 1'b1
`define CMB_WORD_RESET 16'h0000
`define CMB_RESP_OKAY 2'h0
`define CMB_RESP_SLVERR 2'h2
`endif

// ### src/cmb_match.v
// receive classifier for transmissions seen on the shared unit bus
`timescale 1ns/100ps
module cmb_match (
  input wire bus_valid,
  input wire [2:0] bus_dest,
  input wire [2:0] bus_src,
  input wire [2:0] own_code,
  input wire [2:0] expected_src,
  input wire expecting,
  output wire take_data,
  output wire odd_source
);
  // ----------------------------------------------------------------
  // dest comparator and source comparator
  // ----------------------------------------------------------------
  wire to_me;
  assign to_me = bus_valid && (bus_dest == own_code);
  // expected reply from the saved destination: data may be taken
  assign take_data = to_me && expecting && (bus_src == expected_src);
  // anything else addressed here raises the module interrupt
  assign odd_source = to_me && !take_data;
endmodule // cmb_match

// ### src/cmb_unit.v
// cpu side module bus command unit: commands, self transfers, monitor
`timescale 1ns/100ps
`include "cmb_consts.vh"
module cmb_unit (
  input wire clk,
  input wire reset,
  input wire [2:0] field_code,
  input wire [15:0] result_bus,
  input wire [2:0] own_code_in,
  input wire dest_ready_in,
  input wire priority_enable_line_n,
  input wire bus_valid_in,
  input wire [2:0] bus_dest_in,
  input wire [2:0] bus_src_in,
  input wire [1:0] bus_opc_in,
  input wire [15:0] shared_bus_data_lines_in,
  output reg priority_request_n_q,
  output reg bus_drive_q,
  output reg [2:0] bus_dest_q,
  output reg [2:0] bus_src_q,
  output reg [1:0] bus_opc_q,
  output reg [15:0] shared_bus_data_lines_q,
  output reg busy_q,
  output reg module_irq_q,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // pick a field by its msb-first bit number
  function [2:0] field3;
    input [15:0] w;
    input integer first;
    begin
      field3 = {w[15 - first], w[14 - first], w[13 - first]};
    end
  endfunction
  function [1:0] field2;
    input [15:0] w;
    input integer first;
    begin
      field2 = {w[15 - first], w[14 - first]};
    end
  endfunction
  // place a value at msb-first bit numbers inside a zero word
  function [15:0] put_origin;
    input [2:0] src;
    input [1:0] opc;
    reg [15:0] t;
    begin
      t = 16'h0000;
      t[15 - `CMB_ORG_SRC_FIRST] = src[2];
      t[14 - `CMB_ORG_SRC_FIRST] = src[1];
      t[13 - `CMB_ORG_SRC_FIRST] = src[0];
      t[15 - `CMB_ORG_OPC_FIRST] = opc[1];
      t[14 - `CMB_ORG_OPC_FIRST] = opc[0];
      put_origin = t;
    end
  endfunction
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  localparam ST_IDLE = 2'h0; // nothing queued
  localparam ST_LOW = 2'h1; // low request waiting
  localparam ST_HIGH = 2'h2; // high request waiting
  localparam ST_SEND = 2'h3; // driving the bus this cycle
  reg [1:0] state_q;
  reg [2:0] dest_q; // destination module register
  reg [1:0] module_opcode_q; // module opcode register
  reg [15:0] address_out_register_q;
  reg [15:0] data_out_register_q;
  reg send_data_q; // self transfer: data register goes out
  reg prefix_seen_q; // a control prefix preceded this line
  reg next_fetch_pending_q;
  reg operand_fetch_pending_q;
  reg [15:0] origin_code_register_q;
  reg [15:0] next_instruction_register_q;
  reg [15:0] operand_register_q;
  reg status_flag_q; // status word bit for module interrupt
  reg enable_q; // software enable for microcode codes
  reg [2:0] own_q; // jumpered source code, caught after reset
  wire take_data;
  wire odd_source;
  wire wr_en;
  wire [7:0] wr_addr;
  wire [15:0] wr_data;
  wire [7:0] rd_addr;
  reg [15:0] rd_data;
  reg rd_hit;
  wire granted;
  wire accept_code;
  assign granted = !priority_enable_line_n;
  // new codes are only honoured with nothing in flight
  assign accept_code = enable_q && (state_q == ST_IDLE);
  // ----------------------------------------------------------------
  // bus receive classification
  // ----------------------------------------------------------------
  cmb_match u_match (
    .bus_valid(bus_valid_in),
    .bus_dest(bus_dest_in),
    .bus_src(bus_src_in),
    .own_code(own_q),
    .expected_src(dest_q),
    .expecting(next_fetch_pending_q || operand_fetch_pending_q),
    .take_data(take_data),
    .odd_source(odd_source)
  );
  // ----------------------------------------------------------------
  // register front end
  // ----------------------------------------------------------------
  cmb_axil u_axil (
    .clk(clk),
    .reset(reset),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en_q(wr_en),
    .wr_addr_q(wr_addr),
    .wr_data_q(wr_data),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_hit(rd_hit)
  );
  // read mux; status shows pending and request state
  always @* begin
    rd_hit = 1'b1;
    rd_data = 16'h0000;
    case (rd_addr)
      `CMB_ADDR_CTRL: rd_data = {15'h0000, enable_q};
      `CMB_ADDR_STATUS: begin
        rd_data[`CMB_STATUS_FLAG_BIT] = status_flag_q;
        rd_data[3:0] = {state_q, operand_fetch_pending_q,
          next_fetch_pending_q};
      end
      `CMB_ADDR_ORIGIN: rd_data = origin_code_register_q;
      `CMB_ADDR_NEXT: rd_data = next_instruction_register_q;
      `CMB_ADDR_OPERAND_REGISTER: rd_data = operand_register_q;
      `CMB_ADDR_OWN: rd_data = {13'h0000, own_q};
      default: rd_hit = 1'b0;
    endcase
  end
  // ----------------------------------------------------------------
  // microcode capture and request sequencer
  // ----------------------------------------------------------------
  // capture registers only load in idle, so a pending transfer
  // cannot be overwritten by later microcode lines
  always @(posedge clk) begin
    if (reset) begin
      state_q <= ST_IDLE;
      dest_q <= 3'h0;
      module_opcode_q <= `CMB_OPC_NOP;
      address_out_register_q <= `CMB_WORD_RESET;
      data_out_register_q <= `CMB_WORD_RESET;
      send_data_q <= 1'b0;
      prefix_seen_q <= 1'b0;
      own_q <= 3'h0;
    end else begin
      // strap is caught on every clock, so it is valid after release
      own_q <= own_code_in;
      case (state_q)
        ST_IDLE: begin
          if (accept_code) begin
            case (field_code)
              `CMB_FC_CTRL: begin
                dest_q <= field3(result_bus, `CMB_DEST_FIRST);
                module_opcode_q <=
                  field2(result_bus, `CMB_OPC_FIRST);
                prefix_seen_q <= 1'b1;
              end
              `CMB_FC_CMD: begin
                // a command without a prefix has no target
                if (prefix_seen_q) begin
                  address_out_register_q <= result_bus;
                  send_data_q <= 1'b0;
                  prefix_seen_q <= 1'b0;
                  state_q <= ST_LOW;
                end
              end
              `CMB_FC_NEXT, `CMB_FC_OPERAND_REGISTER: begin
                data_out_register_q <= result_bus;
                module_opcode_q <= `CMB_OPC_NOP;
                dest_q <= own_q;
                send_data_q <= 1'b1;
                state_q <= ST_HIGH;
              end
              default: begin
                state_q <= ST_IDLE;
              end
            endcase
          end
        end
        ST_LOW: begin
          // readiness is checked before entering the contest
          if (dest_ready_in && granted) begin
            state_q <= ST_SEND;
          end
        end
        ST_HIGH: begin
          // the receiver expects this, so no ready
          if (granted) begin
            state_q <= ST_SEND;
          end
        end
        ST_SEND: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end
  // ----------------------------------------------------------------
  // bus drivers, all registered
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      priority_request_n_q <= 1'b1;
      bus_drive_q <= 1'b0;
      bus_dest_q <= 3'h0;
      bus_src_q <= 3'h0;
      bus_opc_q <= 2'h0;
      shared_bus_data_lines_q <= 16'h0000;
      busy_q <= 1'b0;
    end else begin
      busy_q <= (state_q != ST_IDLE) && !(state_q == ST_SEND);
      // request line asserted while waiting; low request only once
      // the destination has shown ready
      priority_request_n_q <= !((state_q == ST_HIGH) ||
        ((state_q == ST_LOW) && dest_ready_in));
      bus_drive_q <= 1'b0;
      if ((state_q == ST_LOW && dest_ready_in && granted) ||
          (state_q == ST_HIGH && granted)) begin
        bus_drive_q <= 1'b1;
        bus_dest_q <= dest_q;
        bus_src_q <= own_q;
        bus_opc_q <= module_opcode_q;
        // command sends the address word, self transfer the data
        shared_bus_data_lines_q <= send_data_q ?
          data_out_register_q : address_out_register_q;
      end
    end
  end
  // ----------------------------------------------------------------
  // receive side and status
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      next_fetch_pending_q <= 1'b0;
      operand_fetch_pending_q <= 1'b0;
      origin_code_register_q <= `CMB_WORD_RESET;
      next_instruction_register_q <= `CMB_WORD_RESET;
      operand_register_q <= `CMB_WORD_RESET;
      status_flag_q <= 1'b0;
      module_irq_q <= 1'b0;
      enable_q <= `CMB_CTRL_RESET;
    end else begin
      if (wr_en && wr_addr == `CMB_ADDR_CTRL) begin
        enable_q <= wr_data[0];
      end
      // software clear first so a same-cycle event wins
      if (wr_en && wr_addr == `CMB_ADDR_STATUS &&
          wr_data[`CMB_STATUS_FLAG_BIT]) begin
        status_flag_q <= 1'b0;
      end
      if (accept_code && field_code == `CMB_FC_NEXT) begin
        next_fetch_pending_q <= 1'b1;
      end
      if (accept_code && field_code == `CMB_FC_OPERAND_REGISTER) begin
        operand_fetch_pending_q <= 1'b1;
      end
      if (take_data) begin
        // only the awaited reply is stored
        if (next_fetch_pending_q) begin
          next_instruction_register_q <= shared_bus_data_lines_in;
          next_fetch_pending_q <= 1'b0;
        end else begin
          operand_register_q <= shared_bus_data_lines_in;
          operand_fetch_pending_q <= 1'b0;
        end
      end
      if (odd_source) begin
        // data lines are left alone here, only the codes kept
        origin_code_register_q <=
          put_origin(bus_src_in, bus_opc_in);
        status_flag_q <= 1'b1;
      end
      // the other module won priority before driving
      module_irq_q <= odd_source ||
        (status_flag_q && !(wr_en && wr_addr == `CMB_ADDR_STATUS &&
        wr_data[`CMB_STATUS_FLAG_BIT]));
    end
  end
endmodule // cmb_unit

// ### verif/cmb_far_model.sv
// far side of the shared unit bus: grant, readiness, echo, other modules
`timescale 1ns/100ps
module cmb_far_model (
  input wire clk,
  input wire reset,
  input wire [2:0] own_code_in,
  input wire priority_request_n_q,
  input wire bus_drive_q,
  input wire [23:0] out_word,
  input wire [2:0] mode,
  input wire inj,
  input wire [20:0] inj_word,
  output wire dest_ready_in,
  output reg priority_enable_line_n,
  output wire bus_valid_in,
  output wire [23:0] line_word,
  output reg [7:0] rx_count_q,
  output reg [23:0] rx_word_q
);
  reg [2:0] wait_q; // cycles the slow target has stayed busy
  reg [23:0] last_q; // last value seen on the lines
  // idle lines show the inverse of the last value, never stale data
  assign line_word = bus_drive_q ? out_word
    : inj ? {own_code_in, inj_word} : ~last_q;
  assign bus_valid_in = bus_drive_q | inj;
  // mode[2] keeps the target busy, mode[1] makes it slow to be ready
  assign dest_ready_in = !mode[2] && (!mode[1] || wait_q == 3'h7);
  // ------
  // grant, wait count and capture of commands addressed elsewhere
  // ------
  always @(posedge clk) begin
    if (reset) begin
      wait_q <= 3'h0;
      last_q <= 24'h00_0000;
      priority_enable_line_n <= 1'b1;
      rx_count_q <= 8'h00;
      rx_word_q <= 24'h00_0000;
    end else begin
      // count on its own, the unit only requests once ready shows
      if (!mode[1] || bus_drive_q)
        wait_q <= 3'h0;
      else if (wait_q != 3'h7)
        wait_q <= wait_q + 3'h1;
      // mode[0] or another module's frame withholds priority
      priority_enable_line_n <= mode[0] | priority_request_n_q | inj;
      last_q <= line_word;
      if (bus_drive_q && out_word[23:21] != own_code_in) begin
        rx_count_q <= rx_count_q + 8'h01;
        rx_word_q <= out_word;
      end
    end
  end
endmodule // cmb_far_model

// ### verif/cmb_unit_bench.sv
// self-checking bench for the module bus command unit
`timescale 1ns/100ps
`include "cmb_consts.vh"
module cmb_unit_bench;
  // ------
  // stimulus, observed lines and counters
  // ------
  reg clk, reset, inj;
  reg [2:0] field_code, own_code_in, mode;
  reg [15:0] result_bus;
  reg [20:0] inj_word;
  reg [7:0] s_axi_awaddr, s_axi_araddr;
  reg [31:0] s_axi_wdata;
  reg [3:0] s_axi_wstrb;
  reg s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp, bus_opc_in, bus_opc_q;
  wire [31:0] s_axi_rdata;
  wire dest_ready_in, priority_enable_line_n, bus_valid_in, bus_drive_q;
  wire priority_request_n_q, busy_q, module_irq_q;
  wire [2:0] bus_dest_in, bus_src_in, bus_dest_q, bus_src_q;
  wire [15:0] shared_bus_data_lines_in, shared_bus_data_lines_q;
  wire [7:0] rx_count_q;
  wire [23:0] rx_word_q, line_word, out_word;
  integer err_total, n_compared, cyc, k;
  assign out_word = {bus_dest_q, bus_src_q, bus_opc_q, shared_bus_data_lines_q};
  assign {bus_dest_in, bus_src_in, bus_opc_in, shared_bus_data_lines_in} =
    line_word;
  cmb_unit u_cmb_unit (.clk, .reset, .field_code, .result_bus, .own_code_in,
    .dest_ready_in, .priority_enable_line_n, .bus_valid_in, .bus_dest_in,
    .bus_src_in, .bus_opc_in, .shared_bus_data_lines_in,
    .priority_request_n_q, .bus_drive_q, .bus_dest_q, .bus_src_q, .bus_opc_q,
    .shared_bus_data_lines_q, .busy_q, .module_irq_q, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  cmb_far_model u_cmb_far_model (.clk, .reset, .own_code_in,
    .priority_request_n_q, .bus_drive_q, .out_word, .mode, .inj, .inj_word,
    .dest_ready_in, .priority_enable_line_n, .bus_valid_in, .line_word,
    .rx_count_q, .rx_word_q);
  // ------
  // clock and hang guard, the run needs well under 2000 cycles
  // ------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 6000) begin
      err_total = err_total + 1;
      finish_test;
    end
  end
  task chk(input string nm, input [31:0] exp, input [31:0] got);
    begin
      n_compared = n_compared + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("BAD %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  // axi write: address and data offered together, each dropped when taken
  task wr(input [7:0] a, input [31:0] d, input [1:0] er);
    reg aw, w;
    begin
      aw = 1'b0;
      w = 1'b0;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw && w)) begin
        @(posedge clk);
        if (s_axi_awready === 1'b1 && !aw) begin
          aw = 1'b1;
          s_axi_awvalid <= 1'b0;
        end
        if (s_axi_wready === 1'b1 && !w) begin
          w = 1'b1;
          s_axi_wvalid <= 1'b0;
        end
      end
      while (s_axi_bvalid !== 1'b1) @(posedge clk);
      chk("bresp", er, s_axi_bresp);
      s_axi_bready <= 1'b0;
    end
  endtask
  // axi read: data is compared only when an okay answer is expected
  task rd(input [7:0] a, input [31:0] ed, input [1:0] er);
    begin
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge clk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      while (s_axi_rvalid !== 1'b1) @(posedge clk);
      chk("rresp", er, s_axi_rresp);
      if (er == `CMB_RESP_OKAY)
        chk("rdata", ed, s_axi_rdata);
      s_axi_rready <= 1'b0;
    end
  endtask
  // one microcode line carrying a field code and a result word
  task fc(input [2:0] c, input [15:0] v);
    begin
      @(posedge clk);
      field_code <= c;
      result_bus <= v;
      @(posedge clk);
      field_code <= `CMB_FC_NONE;
      result_bus <= ~v;
    end
  endtask
  task wait_drive;
    reg [7:0] n;
    begin
      n = 8'h00;
      while (bus_drive_q !== 1'b1 && n < 8'h3c) begin
        @(posedge clk);
        n = n + 8'h01;
      end
      chk("drive seen", 32'h0000_0001, bus_drive_q);
      @(posedge clk);
    end
  endtask
  task finish_test;
    begin
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  // ------
  // test sequence
  // ------
  initial begin
    {err_total, n_compared, cyc} = 96'h0;
    {reset, inj, mode, field_code, result_bus, inj_word} = 45'h0;
    reset = 1'b1;
    own_code_in = 3'h1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    s_axi_wstrb = 4'hf;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    rd(`CMB_ADDR_CTRL, 32'h0000_0001, `CMB_RESP_OKAY);
    for (k = 1; k < 5; k = k + 1)
      rd(k * 4, 32'h0000_0000, `CMB_RESP_OKAY);
    rd(`CMB_ADDR_OWN, 32'h0000_0001, `CMB_RESP_OKAY);
    rd(8'h18, 32'h0000_0000, `CMB_RESP_SLVERR);
    wr(`CMB_ADDR_ORIGIN, 32'h0000_ffff, `CMB_RESP_SLVERR);
    $display("test registers done");
    mode <= 3'b010;
    fc(`CMB_FC_CTRL, 16'h0023);
    fc(`CMB_FC_CMD, 16'ha5c3);
    wait_drive;
    chk("command word", 32'h0066_a5c3, rx_word_q);
    fc(`CMB_FC_CMD, 16'h1234);
    repeat (20) @(posedge clk);
    chk("stray command", 32'h0000_0001, rx_count_q);
    $display("test command done");
    for (k = 0; k < 2; k = k + 1) begin
      mode <= 3'b101;
      fc(k ? `CMB_FC_OPERAND_REGISTER : `CMB_FC_NEXT, 16'h3c01 + k);
      rd(`CMB_ADDR_STATUS, 32'h0000_0009 + k, `CMB_RESP_OKAY);
      mode <= 3'b100;
      wait_drive;
      rd(k ? `CMB_ADDR_OPERAND_REGISTER : `CMB_ADDR_NEXT, 32'h3c01 + k, 2'h0);
      rd(`CMB_ADDR_STATUS, 32'h0000_0000, `CMB_RESP_OKAY);
    end
    $display("test self transfers done");
    mode <= 3'b001;
    fc(`CMB_FC_NEXT, 16'h5a5a);
    inj_word <= {3'h5, 2'h2, 16'hdead};
    inj <= 1'b1;
    @(posedge clk);
    inj <= 1'b0;
    repeat (3) @(posedge clk);
    chk("irq", 32'h0000_0001, module_irq_q);
    rd(`CMB_ADDR_STATUS, 32'h0000_0089, `CMB_RESP_OKAY);
    rd(`CMB_ADDR_ORIGIN, 32'h0000_2500, `CMB_RESP_OKAY);
    rd(`CMB_ADDR_NEXT, 32'h0000_3c01, `CMB_RESP_OKAY);
    mode <= 3'b000;
    wait_drive;
    rd(`CMB_ADDR_NEXT, 32'h0000_5a5a, `CMB_RESP_OKAY);
    wr(`CMB_ADDR_STATUS, 32'h0000_0080, `CMB_RESP_OKAY);
    rd(`CMB_ADDR_STATUS, 32'h0000_0000, `CMB_RESP_OKAY);
    chk("irq cleared", 32'h0000_0000, module_irq_q);
    $display("test unsolicited done");
    wr(`CMB_ADDR_CTRL, 32'h0000_0000, `CMB_RESP_OKAY);
    fc(`CMB_FC_NEXT, 16'h7777);
    repeat (4) @(posedge clk);
    chk("busy while off", 32'h0000_0000, busy_q);
    wr(`CMB_ADDR_CTRL, 32'h0000_0001, `CMB_RESP_OKAY);
    rd(`CMB_ADDR_STATUS, 32'h0000_0000, `CMB_RESP_OKAY);
    $display("test enable done");
    finish_test;
  end
endmodule // cmb_unit_bench
bind cmb_unit cmb_unit_monitor u_cmb_unit_monitor (.clk, .reset,
  .own_code_in, .dest_ready_in, .priority_enable_line_n, .bus_valid_in,
  .priority_request_n_q, .bus_drive_q, .bus_dest_q, .bus_src_q, .bus_opc_q,
  .shared_bus_data_lines_q, .busy_q, .module_irq_q);

// ### verif/cmb_unit_monitor.sv
// port assertions for the command unit
`timescale 1ns/100ps
module cmb_unit_monitor (
  input wire clk,
  input wire reset,
  input wire [2:0] own_code_in,
  input wire dest_ready_in,
  input wire priority_enable_line_n,
  input wire bus_valid_in,
  input wire priority_request_n_q,
  input wire bus_drive_q,
  input wire [2:0] bus_dest_q,
  input wire [2:0] bus_src_q,
  input wire [1:0] bus_opc_q,
  input wire [15:0] shared_bus_data_lines_q,
  input wire busy_q,
  input wire module_irq_q
);
  // ------
  // one clock domain, reset silences all checks
  // ------
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  src_own_a: assert property (
    bus_drive_q |-> bus_src_q == own_code_in)
    else $error("source lines differ from own code");
  grant_first_a: assert property (
    $rose(bus_drive_q) |-> !$past(priority_enable_line_n)
      && !$past(priority_request_n_q))
    else $error("bus driven without request and grant");
  one_pulse_a: assert property (
    bus_drive_q |=> !bus_drive_q)
    else $error("drive pulse longer than one cycle");
  ready_first_a: assert property (
    bus_drive_q && bus_dest_q != own_code_in |-> $past(dest_ready_in))
    else $error("command sent to a busy destination");
  self_nop_a: assert property (
    bus_drive_q && bus_dest_q == own_code_in |-> bus_opc_q == 2'h0)
    else $error("self transfer opcode is not no-op");
  req_queued_a: assert property (
    $fell(priority_request_n_q) |-> busy_q)
    else $error("request raised with nothing queued");
  irq_cause_a: assert property (
    $rose(module_irq_q) |-> $past(bus_valid_in) || $past(bus_valid_in, 2))
    else $error("interrupt without a bus transmission");
  out_hold_a: assert property (
    bus_drive_q |=> $stable(shared_bus_data_lines_q) && $stable(bus_dest_q))
    else $error("transfer registers moved after the drive");
endmodule // cmb_unit_monitor
